// ===== hdl/adcsp_device.sv
// device end: frame decode, register loads, reference select and power modes
module adcsp_device
    import adcsp_pkg::*;
#(
    parameter int REF_WAIT_CYCLES = REF_PWRUP_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    adcsp_if.device link,
    input wire logic [RESULT_BITS-1:0] convResult,
    output logic [CTRL_BITS-1:0] ctrlReg_q,
    output logic [SHORT_BITS-1:0] seqReg_q,
    output logic [SHORT_BITS-1:0] range1Reg_q,
    output logic [SHORT_BITS-1:0] range2Reg_q,
    output logic refInternal_q,
    output adcsp_pwr_t powerMode_q,
    output logic lowPower_q,
    output logic standby_q,
    output logic trackHold_q,
    output logic resultInvalid_q
);
    localparam logic [4:0] EDGE_LAST = 5'(FRAME_BITS);
    localparam logic [4:0] EDGE_CTRL = 5'(CTRL_LATCH_EDGE);
    localparam logic [4:0] EDGE_SHORT = 5'(SHORT_LATCH_EDGE);
    localparam logic [4:0] EDGE_TRACK = 5'(TRACK_RISE_EDGE);
    localparam logic [15:0] REF_WAIT = 16'(REF_WAIT_CYCLES);

    logic [2:0] pinIn;
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic [2:0] sync3_q;
    logic [2:0] filt_q;
    logic [2:0] filtPrev_q;
    logic csFall;
    logic csRise;
    logic sclkFall;
    logic sclkRise;
    logic dinF;
    logic inFrame_q;
    logic [4:0] fallCnt_q;
    logic [4:0] riseCnt_q;
    logic [4:0] edgeNum;
    logic frameFall;
    logic convEnd;
    logic [RX_BITS-2:0] shiftIn_q;
    logic [RX_BITS-1:0] rxWord;
    logic ctrlWrite;
    logic shortWrite;
    logic refOn;
    logic [15:0] refWait_q;
    logic waking;
    logic autoNew;
    adcsp_pwr_t newMode;
    logic [FRAME_BITS-1:0] outShift_q;
    logic dout_q;
    logic doutOe_q;

    // three-stage pin synchronisers; a level is taken once stages two and three agree
    assign pinIn = {link.din, link.sclk, link.csN};
    for (genvar g = 0; g < 3; g++) begin : g_sync
        always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
                sync1_q[g] <= 1'b1;
                sync2_q[g] <= 1'b1;
                sync3_q[g] <= 1'b1;
                filt_q[g] <= 1'b1;
                filtPrev_q[g] <= 1'b1;
            end else begin
                sync1_q[g] <= pinIn[g];
                sync2_q[g] <= sync1_q[g];
                sync3_q[g] <= sync2_q[g];
                if (sync2_q[g] == sync3_q[g]) begin
                    filt_q[g] <= sync3_q[g];
                end
                filtPrev_q[g] <= filt_q[g];
            end
        end
    end

    assign csFall = filtPrev_q[0] & ~filt_q[0];
    assign csRise = ~filtPrev_q[0] & filt_q[0];
    assign sclkFall = filtPrev_q[1] & ~filt_q[1] & inFrame_q & ~filt_q[0];
    assign sclkRise = ~filtPrev_q[1] & filt_q[1] & inFrame_q & ~filt_q[0];
    assign dinF = filt_q[2];

    assign edgeNum = fallCnt_q + 5'h01;
    assign frameFall = sclkFall && (fallCnt_q < EDGE_LAST);
    assign convEnd = frameFall && (edgeNum == EDGE_LAST);
    assign rxWord = {shiftIn_q, dinF};
    // header is write bit then two select bits, followed by the data
    assign ctrlWrite = frameFall && (edgeNum == EDGE_CTRL) && rxWord[14] && (rxWord[13:12] == SEL_CTRL);
    assign shortWrite = frameFall && (edgeNum == EDGE_SHORT) && rxWord[10] && (rxWord[9:8] != SEL_CTRL);
    assign refOn = ctrlWrite && rxWord[CTRL_REF_BIT] && !refInternal_q;
    assign newMode = adcsp_decode_pm(ctrlReg_q[CTRL_PM_HI_BIT], ctrlReg_q[CTRL_PM_LO_BIT]);
    assign autoNew = (newMode == PWR_AUTO_SHUT) || (newMode == PWR_AUTO_STBY);
    assign waking = ((powerMode_q == PWR_AUTO_SHUT) || (powerMode_q == PWR_AUTO_STBY)) && (lowPower_q || standby_q);

    // frame bit counters
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            inFrame_q <= 1'b0;
            fallCnt_q <= 5'h00;
            riseCnt_q <= 5'h00;
            shiftIn_q <= '0;
        end else if (csFall) begin
            inFrame_q <= 1'b1;
            fallCnt_q <= 5'h00;
            riseCnt_q <= 5'h00;
            shiftIn_q <= '0;
        end else if (csRise) begin
            inFrame_q <= 1'b0;
        end else begin
            if (frameFall) begin
                fallCnt_q <= edgeNum;
                shiftIn_q <= rxWord[RX_BITS-2:0];
            end
            if (sclkRise && (riseCnt_q != 5'h1f)) begin
                riseCnt_q <= riseCnt_q + 5'h01;
            end
        end
    end

    // on-chip registers; an aborted frame stops before its latch edge and stores nothing
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrlReg_q <= CTRL_RESET;
            refInternal_q <= 1'b0;
            seqReg_q <= SEQ_RESET;
            range1Reg_q <= RANGE_RESET;
            range2Reg_q <= RANGE_RESET;
        end else begin
            if (ctrlWrite) begin
                ctrlReg_q <= rxWord[CTRL_BITS-1:0];
                refInternal_q <= rxWord[CTRL_REF_BIT];
            end
            if (shortWrite) begin
                unique case (rxWord[9:8])
                    SEL_RANGE1: range1Reg_q <= rxWord[SHORT_BITS-1:0];
                    SEL_RANGE2: range2Reg_q <= rxWord[SHORT_BITS-1:0];
                    SEL_SEQ: seqReg_q <= rxWord[SHORT_BITS-1:0];
                    default: seqReg_q <= seqReg_q;
                endcase
            end
        end
    end

    // reference buffer power-up window and result validity
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            refWait_q <= 16'h0000;
        end else if (refOn) begin
            refWait_q <= REF_WAIT;
        end else if (refWait_q != 16'h0000) begin
            refWait_q <= refWait_q - 16'h0001;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            resultInvalid_q <= 1'b0;
        end else if (csFall) begin
            resultInvalid_q <= (refWait_q != 16'h0000) || waking;
        end else if (refOn) begin
            resultInvalid_q <= 1'b1;
        end
    end

    // power state: modes change at conversion end outside full shutdown, and again at every select rise
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            powerMode_q <= PWR_NORMAL;
            lowPower_q <= 1'b0;
            standby_q <= 1'b0;
        end else if (csFall) begin
            if (waking) begin
                lowPower_q <= 1'b0;
                standby_q <= 1'b0;
            end
        end else if ((convEnd && (powerMode_q != PWR_FULL_SHUT)) || csRise) begin
            powerMode_q <= newMode;
            lowPower_q <= (newMode == PWR_FULL_SHUT) || (newMode == PWR_AUTO_SHUT);
            standby_q <= (newMode == PWR_AUTO_STBY);
        end
    end

    // track-and-hold, high while holding
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            trackHold_q <= 1'b0;
        end else if (csFall) begin
            trackHold_q <= !waking;
        end else if (sclkRise && (riseCnt_q + 5'h01 == EDGE_TRACK)) begin
            trackHold_q <= 1'b0;
        end else if (convEnd && autoNew) begin
            trackHold_q <= 1'b1;
        end
    end

    // result shifter and output enable
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            outShift_q <= '0;
            dout_q <= 1'b0;
            doutOe_q <= 1'b0;
        end else if (csFall) begin
            outShift_q <= {ctrlReg_q[CTRL_CHAN_MSB -: CHAN_BITS], convResult};
            dout_q <= ctrlReg_q[CTRL_CHAN_MSB];
            doutOe_q <= 1'b1;
        end else if (csRise) begin
            doutOe_q <= 1'b0;
        end else if (frameFall) begin
            if (edgeNum == EDGE_LAST) begin
                doutOe_q <= 1'b0;
            end else begin
                outShift_q <= {outShift_q[FRAME_BITS-2:0], 1'b0};
                dout_q <= outShift_q[FRAME_BITS-2];
            end
        end
    end

    assign link.dout = dout_q;
    assign link.doutOe = doutOe_q;
endmodule

// ===== hdl/adcsp_host.sv
// host end: AXI4-Lite command registers and serial frame generator
module adcsp_host
    import adcsp_pkg::*;
#(
    parameter int SCLK_HALF = SCLK_HALF_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    adcsp_if.host link,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_END, H_QUIET} adcsp_hstate_t;

    localparam logic [7:0] HALF_LOAD = 8'(SCLK_HALF - 1);
    localparam logic [7:0] QUIET_LOAD = 8'(QUIET_CYCLES);
    localparam logic [7:0] WAKE_LOAD = 8'(QUIET_CYCLES + WAKE_CYCLES);
    localparam logic [4:0] LAST_BIT = 5'(FRAME_BITS);

    adcsp_hstate_t state_q;
    logic [1:0] pinIn;
    logic [1:0] sync1_q;
    logic [1:0] sync2_q;
    logic [1:0] sync3_q;
    logic [1:0] filt_q;
    logic [7:0] halfCnt_q;
    logic tick;
    logic [7:0] waitCnt_q;
    logic [4:0] bitCnt_q;
    logic [15:0] txShift_q;
    logic [15:0] rxShift_q;
    logic [15:0] result_q;
    logic discard_q;
    logic longWait_q;
    logic resultReady_q;
    logic busy;
    logic csN_q;
    logic sclk_q;
    logic din_q;
    logic awHeld_q;
    logic wHeld_q;
    logic [3:0] awAddr_q;
    logic [31:0] wData_q;
    logic doWrite;
    logic cmdStart;
    logic quietDone;
    logic readResult;

    // three-stage synchronisers on the returned data and its enable
    assign pinIn = {link.doutOe, link.dout};
    for (genvar g = 0; g < 2; g++) begin : g_sync
        always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
                sync1_q[g] <= 1'b0;
                sync2_q[g] <= 1'b0;
                sync3_q[g] <= 1'b0;
                filt_q[g] <= 1'b0;
            end else begin
                sync1_q[g] <= pinIn[g];
                sync2_q[g] <= sync1_q[g];
                sync3_q[g] <= sync2_q[g];
                if (sync2_q[g] == sync3_q[g]) begin
                    filt_q[g] <= sync3_q[g];
                end
            end
        end
    end

    assign busy = (state_q != H_IDLE);
    assign tick = (halfCnt_q == 8'h00);
    assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
    assign cmdStart = doWrite && (awAddr_q == REG_CMD) && !busy;
    assign quietDone = (state_q == H_QUIET) && (waitCnt_q == 8'h00);
    assign readResult = s_axi_arvalid && s_axi_arready && (s_axi_araddr == REG_RESULT);

    // half-period divider for the serial clock
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            halfCnt_q <= HALF_LOAD;
        end else if ((state_q == H_IDLE) || tick) begin
            halfCnt_q <= HALF_LOAD;
        end else begin
            halfCnt_q <= halfCnt_q - 8'h01;
        end
    end

    // frame sequencer: data changes on rising edges, device samples on falling ones
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= H_IDLE;
            csN_q <= 1'b1;
            sclk_q <= 1'b1;
            din_q <= 1'b0;
            bitCnt_q <= 5'h00;
            txShift_q <= 16'h0000;
            rxShift_q <= 16'h0000;
            result_q <= 16'h0000;
            waitCnt_q <= 8'h00;
            discard_q <= 1'b0;
            longWait_q <= 1'b0;
        end else begin
            unique case (state_q)
                H_IDLE: begin
                    if (cmdStart) begin
                        csN_q <= 1'b0;
                        txShift_q <= wData_q[15:0];
                        din_q <= wData_q[15];
                        discard_q <= wData_q[CMD_DISCARD_BIT];
                        longWait_q <= wData_q[CMD_WAIT_BIT];
                        state_q <= H_SETUP;
                    end
                end
                H_SETUP: begin
                    if (tick) begin
                        rxShift_q <= {rxShift_q[14:0], filt_q[0] & filt_q[1]};
                        sclk_q <= 1'b0;
                        bitCnt_q <= 5'h01;
                        state_q <= H_LOW;
                    end
                end
                H_LOW: begin
                    if (tick) begin
                        sclk_q <= 1'b1;
                        if (bitCnt_q == LAST_BIT) begin
                            state_q <= H_END;
                        end else begin
                            txShift_q <= {txShift_q[14:0], 1'b0};
                            din_q <= txShift_q[14];
                            state_q <= H_HIGH;
                        end
                    end
                end
                H_HIGH: begin
                    if (tick) begin
                        rxShift_q <= {rxShift_q[14:0], filt_q[0] & filt_q[1]};
                        sclk_q <= 1'b0;
                        bitCnt_q <= bitCnt_q + 5'h01;
                        state_q <= H_LOW;
                    end
                end
                H_END: begin
                    if (tick) begin
                        csN_q <= 1'b1;
                        waitCnt_q <= longWait_q ? WAKE_LOAD : QUIET_LOAD;
                        state_q <= H_QUIET;
                    end
                end
                H_QUIET: begin
                    if (waitCnt_q == 8'h00) begin
                        if (!discard_q) begin
                            result_q <= rxShift_q;
                        end
                        state_q <= H_IDLE;
                    end else begin
                        waitCnt_q <= waitCnt_q - 8'h01;
                    end
                end
            endcase
        end
    end

    // result-ready flag, set wins over the clearing read
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            resultReady_q <= 1'b0;
        end else if (quietDone && !discard_q) begin
            resultReady_q <= 1'b1;
        end else if (readResult) begin
            resultReady_q <= 1'b0;
        end
    end

    // write channels, taken independently, answered once both are held
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= 4'h0;
            wData_q <= 32'h0000_0000;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awAddr_q <= s_axi_awaddr;
                awHeld_q <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wData_q <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                          {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
                wHeld_q <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                if (awAddr_q == REG_CMD) begin
                    s_axi_bresp <= busy ? RESP_SLVERR : RESP_OKAY;
                end else if ((awAddr_q == REG_STATUS) || (awAddr_q == REG_RESULT)) begin
                    s_axi_bresp <= RESP_OKAY;
                end else begin
                    s_axi_bresp <= RESP_DECERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // read channel
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            unique case (s_axi_araddr)
                REG_CMD: s_axi_rdata <= 32'h0000_0000;
                REG_STATUS: s_axi_rdata <= {30'h0000_0000, resultReady_q, busy};
                REG_RESULT: s_axi_rdata <= {16'h0000, result_q};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_DECERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    assign link.csN = csN_q;
    assign link.sclk = sclk_q;
    assign link.din = din_q;
endmodule

// ===== hdl/adcsp_if.sv
// serial link wires between the device end and the host controller
interface adcsp_if;
    logic csN;
    logic sclk;
    logic din;
    logic dout;
    logic doutOe;
    modport device (input csN, input sclk, input din, output dout, output doutOe);
    modport host (output csN, output sclk, output din, input dout, input doutOe);
endinterface

// ===== hdl/adcsp_pkg.sv
// shared constants and types of the serial converter control block
package adcsp_pkg;
    // frame layout
    localparam int FRAME_BITS = 16;
    localparam int CTRL_LATCH_EDGE = 15;
    localparam int SHORT_LATCH_EDGE = 11;
    localparam int TRACK_RISE_EDGE = 14;
    localparam int RX_BITS = 15;
    localparam int CTRL_BITS = 12;
    localparam int SHORT_BITS = 8;
    localparam int RESULT_BITS = 13;
    localparam int CHAN_BITS = 3;
    // register select codes in the frame header
    localparam logic [1:0] SEL_CTRL = 2'h0;
    localparam logic [1:0] SEL_RANGE1 = 2'h1;
    localparam logic [1:0] SEL_RANGE2 = 2'h2;
    localparam logic [1:0] SEL_SEQ = 2'h3;
    // control register fields
    localparam int CTRL_CHAN_MSB = 11;
    localparam int CTRL_PM_HI_BIT = 5;
    localparam int CTRL_PM_LO_BIT = 4;
    localparam int CTRL_REF_BIT = 2;
    // reset values
    localparam logic [11:0] CTRL_RESET = 12'h000;
    localparam logic [7:0] RANGE_RESET = 8'h00;
    localparam logic [7:0] SEQ_RESET = 8'h00;
    // timing
    localparam int SYS_CLK_MHZ = 40;
    localparam int QUIET_NS = 50;
    localparam int QUIET_CYCLES = (QUIET_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int WAKE_NS = 1000;
    localparam int WAKE_CYCLES = (WAKE_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int REF_PWRUP_NS = 1000;
    localparam int REF_PWRUP_CYCLES = (REF_PWRUP_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int SCLK_HALF_CYCLES = 10;
    // host register map and command fields
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_RESULT = 4'h8;
    localparam int CMD_DISCARD_BIT = 16;
    localparam int CMD_WAIT_BIT = 17;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {PWR_NORMAL, PWR_FULL_SHUT, PWR_AUTO_SHUT, PWR_AUTO_STBY} adcsp_pwr_t;

    function automatic adcsp_pwr_t adcsp_decode_pm(input logic hi, input logic lo);
        adcsp_pwr_t m;
        unique case ({hi, lo})
            2'h0: m = PWR_NORMAL;
            2'h3: m = PWR_FULL_SHUT;
            2'h2: m = PWR_AUTO_SHUT;
            2'h1: m = PWR_AUTO_STBY;
        endcase
        return m;
    endfunction
endpackage

// ===== tb/adcsp_link_asserts.sv
// link checks between the device end and the host end
module adcsp_link_asserts #(parameter int SCLK_HALF = 10) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic csN,
    input wire logic sclk,
    input wire logic din,
    input wire logic dout,
    input wire logic doutOe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [9:0] lowCnt_q;
    logic [4:0] fallCnt_q;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    always_ff @(posedge sys_clk or negedge reset_n)
        if (!reset_n) lowCnt_q <= 10'h0;
        else lowCnt_q <= csN ? 10'h0 : lowCnt_q + 10'h1;
    always_ff @(posedge sys_clk or negedge reset_n)
        if (!reset_n) fallCnt_q <= 5'h0;
        else if (csN) fallCnt_q <= 5'h0;
        else if ($fell(sclk)) fallCnt_q <= fallCnt_q + 5'h1;
    AST_OE_ON: assert property ($fell(csN) |-> ##[1:8] doutOe)
        else $error("output not driven after select fall");
    AST_OE_IDLE: assert property (csN [*8] |-> !doutOe)
        else $error("output driven outside frame");
    AST_OE_END: assert property ($fell(sclk) && fallCnt_q == 5'hf |-> ##[1:8] !doutOe)
        else $error("output not released after last fall");
    AST_OE_HOLD: assert property (doutOe && !csN && fallCnt_q < 5'h10 |=> doutOe)
        else $error("output released early");
    AST_DOUT_STABLE: assert property (doutOe && $past(doutOe) && sclk && !csN |-> $stable(dout))
        else $error("output bit moved while clock high");
    AST_QUIET: assert property ($rose(csN) |-> csN [*2])
        else $error("select high too briefly between frames");
    AST_SCLK_IDLE: assert property (csN |-> sclk)
        else $error("serial clock low outside frame");
    AST_FRAME_LEN: assert property ($rose(csN) |-> lowCnt_q == 10'(33 * SCLK_HALF))
        else $error("frame length wrong");
    AST_FALLS: assert property ($rose(csN) |-> fallCnt_q == 5'h10)
        else $error("frame clock count wrong");
    AST_DIN_STABLE: assert property (!csN && !$fell(csN) && $changed(din) |-> $rose(sclk))
        else $error("input bit moved off clock rise");
    cover property ($rose(csN) && fallCnt_q == 5'h10);
    cover property (doutOe && dout);
    cover property (!csN && $changed(din));
endmodule

// ===== tb/testbench.sv
// self-checking bench for both ends of the serial converter link
module testbench import adcsp_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0, reset_n = 1'b0, awv = 1'b0, wv = 1'b0, bRdy = 1'b0, arv = 1'b0, rRdy = 1'b0;
    logic [12:0] conv = 13'h0;
    logic [3:0] awa = 4'h0, ara = 4'h0;
    logic [31:0] wd = 32'h0000_0000, rd;
    logic awRdy, wRdy, bv, arRdy, rv, refInt, lowPwr, stby, track, resInv;
    logic [1:0] bResp, rResp;
    logic [11:0] ctrl;
    logic [7:0] seqR, rng1, rng2;
    adcsp_pwr_t pmode;
    int failures = 0, check_count = 0;
    adcsp_if link();
    adcsp_device #(.REF_WAIT_CYCLES(4)) adcsp_device_inst (.sys_clk(sys_clk), .reset_n(reset_n), .link(link),
        .convResult(conv), .ctrlReg_q(ctrl), .seqReg_q(seqR), .range1Reg_q(rng1), .range2Reg_q(rng2),
        .refInternal_q(refInt), .powerMode_q(pmode), .lowPower_q(lowPwr), .standby_q(stby),
        .trackHold_q(track), .resultInvalid_q(resInv));
    adcsp_host adcsp_host_inst (.sys_clk(sys_clk), .reset_n(reset_n), .link(link), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awRdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wRdy), .s_axi_bresp(bResp), .s_axi_bvalid(bv), .s_axi_bready(bRdy), .s_axi_araddr(ara),
        .s_axi_arvalid(arv), .s_axi_arready(arRdy), .s_axi_rdata(rd), .s_axi_rresp(rResp), .s_axi_rvalid(rv),
        .s_axi_rready(rRdy));
    adcsp_link_asserts #(.SCLK_HALF(SCLK_HALF_CYCLES)) adcsp_link_asserts_inst (.sys_clk(sys_clk),
        .reset_n(reset_n), .csN(link.csN), .sclk(link.sclk), .din(link.din), .dout(link.dout),
        .doutOe(link.doutOe));
    always #12.5 sys_clk = ~sys_clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bRdy <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awRdy) awv <= 1'b0;
            if (wRdy) wv <= 1'b0;
        end while (bv !== 1'b1);
        r = bResp; bRdy <= 1'b0;
    endtask
    task automatic rdw(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        ara <= a; arv <= 1'b1; rRdy <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arRdy) arv <= 1'b0;
        end while (rv !== 1'b1);
        d = rd; r = rResp; rRdy <= 1'b0;
    endtask
    // send one frame and wait until the host is idle again
    task automatic frame(input logic [15:0] w);
        logic [31:0] d;
        logic [1:0] r;
        wr(REG_CMD, {16'h0000, w}, r);
        check(32'(r), 32'(RESP_OKAY));
        do rdw(REG_STATUS, d, r); while (d[0] !== 1'b0);
    endtask
    task automatic test_reset();
        check(32'(ctrl), 32'h0000_0000);
        check({8'h00, seqR, rng1, rng2}, 32'h0000_0000);
        check(32'(refInt), 32'h0);
        check(32'(pmode), 32'(PWR_NORMAL));
        $display("reset test done");
    endtask
    task automatic test_regs();
        frame({1'b1, SEL_RANGE1, 8'ha5, 5'h00});
        frame({1'b1, SEL_RANGE2, 8'h5a, 5'h00});
        frame({1'b1, SEL_SEQ, 8'h3c, 5'h00});
        frame({1'b0, SEL_SEQ, 8'hff, 5'h00});
        check({8'h00, rng1, rng2, seqR}, 32'h00a5_5a3c);
        $display("register test done");
    endtask
    task automatic test_modes();
        logic [1:0] pm [8] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h0};
        adcsp_pwr_t modeOf [4] = '{PWR_NORMAL, PWR_AUTO_STBY, PWR_AUTO_SHUT, PWR_FULL_SHUT};
        for (int i = 0; i < 8; i++) begin
            frame({1'b1, SEL_CTRL, 6'h00, pm[i], 4'h0, 1'b0});
            check(32'(ctrl), {26'h0, pm[i], 4'h0});
            check(32'(pmode), 32'(modeOf[pm[i]]));
            check(32'(lowPwr), 32'(pm[i][1]));
            check(32'(stby), 32'(pm[i] == 2'h1));
            if (i == 0 || (pm[i] == pm[i-1] && pm[i] != 2'h3)) check(32'(track), 32'(^pm[i]));
            if (i > 0) check(32'(resInv), 32'(^pm[i-1]));
        end
        $display("power mode test done");
    endtask
    task automatic test_ref_result();
        logic [31:0] d;
        logic [1:0] r;
        time t0;
        frame({1'b1, SEL_CTRL, 12'ha04, 1'b0});
        check({30'h0, refInt, resInv}, 32'h3);
        conv <= 13'h1abc;
        frame(16'h0000);
        check(32'(ctrl), 32'h0000_0a04);
        rdw(REG_STATUS, d, r);
        check(d, 32'h0000_0002);
        rdw(REG_RESULT, d, r);
        check(d, {16'h0000, 3'h5, 13'h1abc});
        conv <= 13'h0123;
        wr(REG_CMD, 32'h0003_0000, r);
        t0 = $time;
        do rdw(REG_STATUS, d, r); while (d[0] !== 1'b0);
        check(32'(($time - t0) >= 25 * (33 * SCLK_HALF_CYCLES + WAKE_CYCLES)), 32'h1);
        check(d, 32'h0000_0000);
        rdw(REG_RESULT, d, r);
        check(d, {16'h0000, 3'h5, 13'h1abc});
        frame({1'b1, SEL_CTRL, 12'h000, 1'b0});
        check(32'(refInt), 32'h0);
        $display("reference and result test done");
    endtask
    task automatic test_axi();
        logic [31:0] d;
        logic [1:0] r;
        rdw(4'hc, d, r);
        check({d[29:0], r}, 32'(RESP_DECERR));
        wr(4'hc, 32'h0000_0001, r);
        check(32'(r), 32'(RESP_DECERR));
        frame(16'h0000);
        wr(REG_CMD, 32'h0000_0000, r);
        wr(REG_CMD, 32'h0000_ffff, r);
        check(32'(r), 32'(RESP_SLVERR));
        do rdw(REG_STATUS, d, r); while (d[0] !== 1'b0);
        check(32'(ctrl), 32'h0);
        $display("bus test done");
    endtask
    initial begin
        #2_000_000;
        failures++;
        test_done();
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        test_reset();
        test_regs();
        test_modes();
        test_ref_result();
        test_axi();
        test_done();
    end
endmodule
